// ===== sdram_timing_pkg.sv
// Purpose: Shared constants and types for the SDRAM command-timing block
// Assumes: One 100 MHz clock; memory clock modelled as an enable pulse
// Notes: Offsets are byte addresses on a 32-bit register port
package sdram_timing_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;

  // Register byte offsets
  localparam logic [11:0] MODE_CMD_GAP_OFS = 12'h01c;
  localparam logic [11:0] ACT_PRE_GAP_OFS = 12'h020;
  localparam logic [11:0] SAME_BANK_ACT_GAP_OFS = 12'h024;
  localparam logic [11:0] ACT_COL_GAP_OFS = 12'h028;
  localparam logic [11:0] REFRESH_CMD_GAP_OFS = 12'h02c;
  localparam logic [11:0] PRE_ACT_GAP_OFS = 12'h030;
  localparam logic [11:0] CROSS_BANK_ACT_GAP_OFS = 12'h034;
  localparam logic [11:0] WRITE_PRE_GAP_OFS = 12'h038;
  localparam logic [11:0] WRITE_READ_GAP_OFS = 12'h03c;
  localparam logic [11:0] PD_EXIT_GAP_OFS = 12'h040;
  localparam logic [11:0] SR_EXIT_GAP_OFS = 12'h044;

  // Field positions; every low field starts at bit 0
  localparam int FIELD_LSB = 0;
  localparam int MRD_W = 7;
  localparam int RAS_W = 4;
  localparam int RC_W = 4;
  localparam int RCD_W = 3;
  localparam int SCHED_RCD_LSB = 3;
  localparam int RFC_W = 5;
  localparam int SCHED_RFC_LSB = 5;
  localparam int RP_W = 3;
  localparam int SCHED_RP_LSB = 3;
  localparam int RRD_W = 4;
  localparam int WR_W = 3;
  localparam int WTR_W = 3;
  localparam int XP_W = 8;
  localparam int XSR_W = 8;

  // Values after reset
  localparam logic [6:0] MRD_RST = 7'h02;
  localparam logic [3:0] RAS_RST = 4'h7;
  localparam logic [3:0] RC_RST = 4'hb;
  localparam logic [2:0] RCD_RST = 3'h5;
  localparam logic [2:0] SCHED_RCD_RST = 3'h2;
  localparam logic [4:0] RFC_RST = 5'h12;
  localparam logic [4:0] SCHED_RFC_RST = 5'h10;
  localparam logic [2:0] RP_RST = 3'h5;
  localparam logic [2:0] SCHED_RP_RST = 3'h2;
  localparam logic [3:0] RRD_RST = 4'h2;
  localparam logic [2:0] WR_RST = 3'h3;
  localparam logic [2:0] WTR_RST = 3'h2;
  localparam logic [7:0] XP_RST = 8'h01;
  localparam logic [7:0] XSR_RST = 8'h0a;

  // Bus-clock schedule copies hold count plus this bias
  localparam logic [7:0] SCHED_BIAS = 8'h03;
  // Core clocks per memory clock
  localparam int MCLK_DIV_DEFAULT = 2;

  typedef enum logic [1:0] {
    CTRL_CONFIG = 2'b00,
    CTRL_READY = 2'b01,
    CTRL_PAUSED = 2'b10,
    CTRL_LOW_POWER = 2'b11
  } ctrl_state_t;

  typedef struct packed {
    logic mode;
    logic activate;
    logic read;
    logic write;
    logic precharge;
    logic refresh;
    logic pd_exit;
    logic sr_exit;
    logic write_end;
    logic [1:0] bank;
  } sdram_cmd_t;

  typedef struct packed {
    logic any_ok;
    logic read_ok;
    logic [3:0] activate_ok;
    logic [3:0] column_ok;
    logic [3:0] precharge_ok;
    logic sched_column_ok;
    logic sched_refresh_ok;
    logic sched_activate_ok;
  } cmd_gate_t;

endpackage

// ===== sdram_timing_params.sv
// Purpose: SDRAM command-timing registers and the spacing counters they drive
// Assumes: Issued commands arrive as one-cycle pulses on cmd_in
// Notes: Gates are registered from the counters' next values, so they change in the same clock as the counters
`timescale 1ns/1ps

// What this block does
// - Registers accessible only in config or low-power
// - Mode command gap, bits 6:0
// - Activate to precharge gap, bits 3:0
// - Same-bank activate gap, bits 3:0
// - Activate to column gap, bits 2:0
// - Scheduler activate-column gap bits 5:3, plus 3
// - Refresh command gap, bits 4:0
// - Scheduler refresh gap bits 9:5, plus 3
// - Precharge to activate gap, bits 2:0
// - Scheduler precharge-activate gap bits 5:3, plus 3
// - Cross-bank activate gap, bits 3:0
// - Write burst end to precharge gap
// - Write to read gap, bits 2:0
// - Power-down exit wait, bits 7:0
// - Self-refresh exit wait, bits 7:0
module sdram_timing_params #(
  parameter int MCLK_DIV = sdram_timing_pkg::MCLK_DIV_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire sdram_timing_pkg::ctrl_state_t ctrl_state_in,
  input wire sdram_timing_pkg::sdram_cmd_t cmd_in,
  output logic [31:0] rdata_out,
  output logic mem_tick_out,
  output sdram_timing_pkg::cmd_gate_t gate_out
);

  localparam int NB = sdram_timing_pkg::NUM_BANKS;
  localparam int CW = sdram_timing_pkg::CNT_W;

  // Decrement on tick, reload with the larger of remaining and new
  function automatic logic [7:0] next_cnt(input logic [7:0] cnt, input logic ld,
                                          input logic [7:0] val, input logic tick);
    logic [7:0] dec;
    dec = (tick && cnt != 8'h00) ? cnt - 8'h01 : cnt;
    next_cnt = (ld && val > dec) ? val : dec;
  endfunction

  // Strobe qualified by a match on the command's bank
  function automatic logic bank_hit(input logic strobe, input logic [1:0] bank, input int b);
    bank_hit = strobe && (bank == 2'(b));
  endfunction

  // Schedule copies are stored as count plus the bias
  function automatic logic [7:0] sched_load(input logic [4:0] field);
    sched_load = {3'b000, field} + sdram_timing_pkg::SCHED_BIAS;
  endfunction

  logic [6:0] mrd_reg;
  logic [3:0] ras_reg;
  logic [3:0] rc_reg;
  logic [2:0] rcd_reg;
  logic [2:0] sched_rcd_reg;
  logic [4:0] rfc_reg;
  logic [4:0] sched_rfc_reg;
  logic [2:0] rp_reg;
  logic [2:0] sched_rp_reg;
  logic [3:0] rrd_reg;
  logic [2:0] wr_reg;
  logic [2:0] wtr_reg;
  logic [7:0] xp_reg;
  logic [7:0] xsr_reg;
  logic access_ok;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic [15:0] div_reg;
  logic tick_reg;

  logic [CW-1:0] gen_reg;
  logic [CW-1:0] gen_next;
  logic [CW-1:0] rrd_cnt_reg;
  logic [CW-1:0] rrd_cnt_next;
  logic [CW-1:0] wtr_cnt_reg;
  logic [CW-1:0] wtr_cnt_next;
  logic [CW-1:0] s_rcd_reg;
  logic [CW-1:0] s_rcd_next;
  logic [CW-1:0] s_rfc_reg;
  logic [CW-1:0] s_rfc_next;
  logic [CW-1:0] s_rp_reg;
  logic [CW-1:0] s_rp_next;
  logic [CW-1:0] ras_cnt_reg [NB];
  logic [CW-1:0] ras_cnt_next [NB];
  logic [CW-1:0] rc_cnt_reg [NB];
  logic [CW-1:0] rc_cnt_next [NB];
  logic [CW-1:0] rcd_cnt_reg [NB];
  logic [CW-1:0] rcd_cnt_next [NB];
  logic [CW-1:0] rp_cnt_reg [NB];
  logic [CW-1:0] rp_cnt_next [NB];
  logic [CW-1:0] wr_cnt_reg [NB];
  logic [CW-1:0] wr_cnt_next [NB];
  logic [1:0] last_act_bank_reg;
  logic [7:0] gen_load;
  logic gen_ld;
  sdram_timing_pkg::cmd_gate_t gate_reg;
  sdram_timing_pkg::cmd_gate_t gate_next;

  // Only config and low-power states open the register port
  assign access_ok = (ctrl_state_in == sdram_timing_pkg::CTRL_CONFIG) ||
                     (ctrl_state_in == sdram_timing_pkg::CTRL_LOW_POWER);

  // Register writes; upper bits are dropped, software keeps them zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mrd_reg <= sdram_timing_pkg::MRD_RST;
      ras_reg <= sdram_timing_pkg::RAS_RST;
      rc_reg <= sdram_timing_pkg::RC_RST;
      rcd_reg <= sdram_timing_pkg::RCD_RST;
      sched_rcd_reg <= sdram_timing_pkg::SCHED_RCD_RST;
      rfc_reg <= sdram_timing_pkg::RFC_RST;
      sched_rfc_reg <= sdram_timing_pkg::SCHED_RFC_RST;
      rp_reg <= sdram_timing_pkg::RP_RST;
      sched_rp_reg <= sdram_timing_pkg::SCHED_RP_RST;
      rrd_reg <= sdram_timing_pkg::RRD_RST;
      wr_reg <= sdram_timing_pkg::WR_RST;
      wtr_reg <= sdram_timing_pkg::WTR_RST;
      xp_reg <= sdram_timing_pkg::XP_RST;
      xsr_reg <= sdram_timing_pkg::XSR_RST;
    end else if (write_in && access_ok) begin
      unique case (addr_in)
        sdram_timing_pkg::MODE_CMD_GAP_OFS: begin
          mrd_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::MRD_W];
        end
        sdram_timing_pkg::ACT_PRE_GAP_OFS: begin
          ras_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RAS_W];
        end
        sdram_timing_pkg::SAME_BANK_ACT_GAP_OFS: begin
          rc_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RC_W];
        end
        sdram_timing_pkg::ACT_COL_GAP_OFS: begin
          rcd_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RCD_W];
          sched_rcd_reg <= wdata_in[sdram_timing_pkg::SCHED_RCD_LSB +: 3];
        end
        sdram_timing_pkg::REFRESH_CMD_GAP_OFS: begin
          rfc_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RFC_W];
          sched_rfc_reg <= wdata_in[sdram_timing_pkg::SCHED_RFC_LSB +: 5];
        end
        sdram_timing_pkg::PRE_ACT_GAP_OFS: begin
          rp_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RP_W];
          sched_rp_reg <= wdata_in[sdram_timing_pkg::SCHED_RP_LSB +: 3];
        end
        sdram_timing_pkg::CROSS_BANK_ACT_GAP_OFS: begin
          rrd_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::RRD_W];
        end
        sdram_timing_pkg::WRITE_PRE_GAP_OFS: begin
          wr_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::WR_W];
        end
        sdram_timing_pkg::WRITE_READ_GAP_OFS: begin
          wtr_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::WTR_W];
        end
        sdram_timing_pkg::PD_EXIT_GAP_OFS: begin
          xp_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::XP_W];
        end
        sdram_timing_pkg::SR_EXIT_GAP_OFS: begin
          xsr_reg <= wdata_in[sdram_timing_pkg::FIELD_LSB +: sdram_timing_pkg::XSR_W];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unused bits, unmapped offsets and closed states read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (read_in && access_ok) begin
      unique case (addr_in)
        sdram_timing_pkg::MODE_CMD_GAP_OFS: begin
          rdata_next = {25'h0, mrd_reg};
        end
        sdram_timing_pkg::ACT_PRE_GAP_OFS: begin
          rdata_next = {28'h0, ras_reg};
        end
        sdram_timing_pkg::SAME_BANK_ACT_GAP_OFS: begin
          rdata_next = {28'h0, rc_reg};
        end
        sdram_timing_pkg::ACT_COL_GAP_OFS: begin
          rdata_next = {26'h0, sched_rcd_reg, rcd_reg};
        end
        sdram_timing_pkg::REFRESH_CMD_GAP_OFS: begin
          rdata_next = {22'h0, sched_rfc_reg, rfc_reg};
        end
        sdram_timing_pkg::PRE_ACT_GAP_OFS: begin
          rdata_next = {26'h0, sched_rp_reg, rp_reg};
        end
        sdram_timing_pkg::CROSS_BANK_ACT_GAP_OFS: begin
          rdata_next = {28'h0, rrd_reg};
        end
        sdram_timing_pkg::WRITE_PRE_GAP_OFS: begin
          rdata_next = {29'h0, wr_reg};
        end
        sdram_timing_pkg::WRITE_READ_GAP_OFS: begin
          rdata_next = {29'h0, wtr_reg};
        end
        sdram_timing_pkg::PD_EXIT_GAP_OFS: begin
          rdata_next = {24'h0, xp_reg};
        end
        sdram_timing_pkg::SR_EXIT_GAP_OFS: begin
          rdata_next = {24'h0, xsr_reg};
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Memory clock divider count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= 16'h0000;
    end else if (div_reg == 16'(MCLK_DIV - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Memory clock enable, one pulse per wrap of the count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == 16'(MCLK_DIV - 1));
    end
  end

  // Commands that stall every following command
  always_comb begin
    gen_ld = cmd_in.mode | cmd_in.refresh | cmd_in.pd_exit | cmd_in.sr_exit;
    gen_load = 8'h00;
    if (cmd_in.mode && {1'b0, mrd_reg} > gen_load) begin
      gen_load = {1'b0, mrd_reg};
    end
    if (cmd_in.refresh && {3'b0, rfc_reg} > gen_load) begin
      gen_load = {3'b0, rfc_reg};
    end
    if (cmd_in.pd_exit && xp_reg > gen_load) begin
      gen_load = xp_reg;
    end
    if (cmd_in.sr_exit && xsr_reg > gen_load) begin
      gen_load = xsr_reg;
    end
  end

  // Next values of all spacing counters
  always_comb begin
    gen_next = next_cnt(gen_reg, gen_ld, gen_load, tick_reg);
    rrd_cnt_next = next_cnt(rrd_cnt_reg, cmd_in.activate, {4'b0, rrd_reg}, tick_reg);
    wtr_cnt_next = next_cnt(wtr_cnt_reg, cmd_in.write, {5'b0, wtr_reg}, tick_reg);
    s_rcd_next = next_cnt(s_rcd_reg, cmd_in.activate,
                          sched_load({2'b00, sched_rcd_reg}), 1'b1);
    s_rfc_next = next_cnt(s_rfc_reg, cmd_in.refresh,
                          sched_load(sched_rfc_reg), 1'b1);
    s_rp_next = next_cnt(s_rp_reg, cmd_in.precharge,
                         sched_load({2'b00, sched_rp_reg}), 1'b1);
    for (int b = 0; b < NB; b++) begin
      ras_cnt_next[b] = next_cnt(ras_cnt_reg[b], bank_hit(cmd_in.activate, cmd_in.bank, b),
                                 {4'b0, ras_reg}, tick_reg);
      rc_cnt_next[b] = next_cnt(rc_cnt_reg[b], bank_hit(cmd_in.activate, cmd_in.bank, b),
                                {4'b0, rc_reg}, tick_reg);
      rcd_cnt_next[b] = next_cnt(rcd_cnt_reg[b], bank_hit(cmd_in.activate, cmd_in.bank, b),
                                 {5'b0, rcd_reg}, tick_reg);
      rp_cnt_next[b] = next_cnt(rp_cnt_reg[b], bank_hit(cmd_in.precharge, cmd_in.bank, b),
                                {5'b0, rp_reg}, tick_reg);
      wr_cnt_next[b] = next_cnt(wr_cnt_reg[b], bank_hit(cmd_in.write_end, cmd_in.bank, b),
                                {5'b0, wr_reg}, tick_reg);
    end
  end

  // Bank-independent memory-clock counters
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gen_reg <= 8'h00;
      rrd_cnt_reg <= 8'h00;
      wtr_cnt_reg <= 8'h00;
    end else begin
      gen_reg <= gen_next;
      rrd_cnt_reg <= rrd_cnt_next;
      wtr_cnt_reg <= wtr_cnt_next;
    end
  end

  // Scheduler copies, counted in core clocks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_rcd_reg <= 8'h00;
      s_rfc_reg <= 8'h00;
      s_rp_reg <= 8'h00;
    end else begin
      s_rcd_reg <= s_rcd_next;
      s_rfc_reg <= s_rfc_next;
      s_rp_reg <= s_rp_next;
    end
  end

  // Per-bank memory-clock counters
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int b = 0; b < NB; b++) begin
        ras_cnt_reg[b] <= 8'h00;
        rc_cnt_reg[b] <= 8'h00;
        rcd_cnt_reg[b] <= 8'h00;
        rp_cnt_reg[b] <= 8'h00;
        wr_cnt_reg[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < NB; b++) begin
        ras_cnt_reg[b] <= ras_cnt_next[b];
        rc_cnt_reg[b] <= rc_cnt_next[b];
        rcd_cnt_reg[b] <= rcd_cnt_next[b];
        rp_cnt_reg[b] <= rp_cnt_next[b];
        wr_cnt_reg[b] <= wr_cnt_next[b];
      end
    end
  end

  // Bank of the latest activate, for the cross-bank gap
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_act_bank_reg <= 2'h0;
    end else if (cmd_in.activate) begin
      last_act_bank_reg <= cmd_in.bank;
    end
  end

  // Gates open only when every relevant counter has expired
  always_comb begin
    gate_next.any_ok = (gen_next == 8'h00);
    gate_next.read_ok = (gen_next == 8'h00) && (wtr_cnt_next == 8'h00);
    for (int b = 0; b < NB; b++) begin
      gate_next.activate_ok[b] = (gen_next == 8'h00) && (rc_cnt_next[b] == 8'h00) &&
                                 (rp_cnt_next[b] == 8'h00) &&
                                 (rrd_cnt_next == 8'h00 ||
                                  last_act_bank_reg == 2'(b));
      gate_next.column_ok[b] = (gen_next == 8'h00) && (rcd_cnt_next[b] == 8'h00);
      gate_next.precharge_ok[b] = (gen_next == 8'h00) && (ras_cnt_next[b] == 8'h00) &&
                                  (wr_cnt_next[b] == 8'h00);
    end
    gate_next.sched_column_ok = (s_rcd_next == 8'h00);
    gate_next.sched_refresh_ok = (s_rfc_next == 8'h00);
    gate_next.sched_activate_ok = (s_rp_next == 8'h00);
  end

  // Counters are clear in reset, so every gate reads open
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_reg <= '1;
    end else begin
      gate_reg <= gate_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign mem_tick_out = tick_reg;
  assign gate_out = gate_reg;

endmodule

// ===== sdram_cmd_issuer.sv
// Purpose: Stand-in for the command scheduler that issues commands to the timing block
// Assumes: One request is given for one clock, with the bank alongside it
// Notes: Each issued command is a registered one-clock pulse
`timescale 1ns/1ps
module sdram_cmd_issuer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire sdram_timing_pkg::sdram_cmd_t req_in,
  output sdram_timing_pkg::sdram_cmd_t cmd_out
);
  sdram_timing_pkg::sdram_cmd_t cmd_reg;

  // One-clock pulse per request, bank travels with it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= req_in;
    end
  end

  assign cmd_out = cmd_reg;
endmodule

// ===== sdram_timing_params_asserts.sv
// Purpose: Port-level checks of the SDRAM command-timing block
// Assumes: Single clock domain, asynchronous active-high reset
// Notes: Mode gap field shadowed here to tie the gate to its setting
`timescale 1ns/1ps
module sdram_timing_params_asserts #(
  parameter int MCLK_DIV = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire sdram_timing_pkg::ctrl_state_t ctrl_state_in,
  input wire sdram_timing_pkg::sdram_cmd_t cmd_in,
  input wire logic [31:0] rdata_out,
  input wire logic mem_tick_out,
  input wire sdram_timing_pkg::cmd_gate_t gate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic open_st;
  logic [6:0] mode_gap_reg;
  logic [15:0] since_tick_reg;
  assign open_st = (ctrl_state_in == sdram_timing_pkg::CTRL_CONFIG) ||
                   (ctrl_state_in == sdram_timing_pkg::CTRL_LOW_POWER);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_gap_reg <= sdram_timing_pkg::MRD_RST;
    end else if (write_in && open_st && addr_in == sdram_timing_pkg::MODE_CMD_GAP_OFS) begin
      mode_gap_reg <= wdata_in[6:0];
    end
  end

  // Clocks since the last memory tick, counted from one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      since_tick_reg <= 16'h0000;
    end else if (mem_tick_out) begin
      since_tick_reg <= 16'h0001;
    end else begin
      since_tick_reg <= since_tick_reg + 16'h0001;
    end
  end

  chk_tick_spacing: assert property (
    mem_tick_out == (since_tick_reg == 16'(MCLK_DIV))) else $error("memory tick spacing");

  chk_closed_read_zero: assert property (
    read_in && !open_st |=> rdata_out == 32'h0000_0000) else $error("closed-state read data");
  chk_idle_rdata_zero: assert property (
    !read_in |=> rdata_out == 32'h0000_0000) else $error("read data without a read");
  chk_mode_readback: assert property (
    read_in && open_st && addr_in == sdram_timing_pkg::MODE_CMD_GAP_OFS
    |=> rdata_out == {25'h000_0000, $past(mode_gap_reg)}) else $error("mode gap readback");
  chk_rcd_upper_zero: assert property (
    read_in && open_st && addr_in == sdram_timing_pkg::ACT_COL_GAP_OFS
    |=> rdata_out[31:6] == 26'h000_0000) else $error("column gap upper bits set");
  chk_mode_gap_close: assert property (
    cmd_in.mode && mode_gap_reg != 7'h00 |=> !gate_out.any_ok) else $error("mode gap open");
  chk_pre_sched_hold: assert property (
    cmd_in.precharge |=> !gate_out.sched_activate_ok [*3]) else $error("sched act gap short");
  chk_act_sched_hold: assert property (
    cmd_in.activate |=> !gate_out.sched_column_ok [*3]) else $error("sched col gap short");
  chk_ref_sched_hold: assert property (
    cmd_in.refresh |=> !gate_out.sched_refresh_ok [*3]) else $error("sched ref gap short");
  chk_reset_gates_open: assert property (
    $fell(rst_in) |-> (&gate_out) && rdata_out == 32'h0000_0000) else $error("gates after reset");

  cover property (read_in && open_st);
  cover property (cmd_in.precharge ##1 !gate_out.sched_activate_ok);
  cover property (cmd_in.mode ##1 !gate_out.any_ok);
endmodule

bind sdram_timing_params sdram_timing_params_asserts #(.MCLK_DIV(MCLK_DIV)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .write_in(write_in), .read_in(read_in), .ctrl_state_in(ctrl_state_in), .cmd_in(cmd_in),
  .rdata_out(rdata_out), .mem_tick_out(mem_tick_out), .gate_out(gate_out));

// ===== testbench.sv
// Purpose: Register and command-gap tests of the SDRAM command-timing block
// Assumes: Memory clock divider of 1, so every count is in core clocks
// Notes: Gap length is the number of cycles the watched gate stays low
`timescale 1ns/1ps
module testbench;
  logic clk_in, rst_in, write_in, read_in;
  logic [11:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  sdram_timing_pkg::ctrl_state_t ctrl_state_in;
  sdram_timing_pkg::sdram_cmd_t req, cmd;
  sdram_timing_pkg::cmd_gate_t gate;
  logic mem_tick;
  logic [$bits(sdram_timing_pkg::cmd_gate_t)-1:0] gbits;
  int err_count, checks, cycles;
  logic [11:0] ofs [11];
  logic [31:0] rst_v [11], pat_v [11], prog_v [11];
  assign gbits = gate;

  sdram_timing_params #(.MCLK_DIV(1)) dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .ctrl_state_in(ctrl_state_in),
    .cmd_in(cmd), .rdata_out(rdata_out), .mem_tick_out(mem_tick), .gate_out(gate));
  sdram_cmd_issuer issuer (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .cmd_out(cmd));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1;
    check(rdata_out, exp);
    @(posedge clk_in);
    #1;
    check(rdata_out, 32'h0000_0000);
  endtask

  task automatic st(input sdram_timing_pkg::ctrl_state_t s);
    @(posedge clk_in);
    ctrl_state_in <= s;
  endtask

  // Issue one command, count cycles the selected gate bit stays low
  task automatic gap(input logic [10:0] c, input int sel, input int exp);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= c;
    @(posedge clk_in);
    req <= '0;
    @(posedge clk_in);
    #1;
    while (gbits[sel] !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    check(32'(n), 32'(exp));
    n = 0;
    while ((&gbits) !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_in);
      #1;
    end
  endtask

  initial begin
    rst_in = 1'b1;
    write_in = 1'b0;
    read_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    req = '0;
    ctrl_state_in = sdram_timing_pkg::CTRL_CONFIG;
    err_count = 0;
    checks = 0;
    cycles = 0;
    for (int i = 0; i < 11; i++) ofs[i] = 12'h01c + 12'(4 * i);
    rst_v = '{{25'h0, sdram_timing_pkg::MRD_RST}, {28'h0, sdram_timing_pkg::RAS_RST},
      {28'h0, sdram_timing_pkg::RC_RST},
      {26'h0, sdram_timing_pkg::SCHED_RCD_RST, sdram_timing_pkg::RCD_RST},
      {22'h0, sdram_timing_pkg::SCHED_RFC_RST, sdram_timing_pkg::RFC_RST},
      {26'h0, sdram_timing_pkg::SCHED_RP_RST, sdram_timing_pkg::RP_RST},
      {28'h0, sdram_timing_pkg::RRD_RST}, {29'h0, sdram_timing_pkg::WR_RST},
      {29'h0, sdram_timing_pkg::WTR_RST}, {24'h0, sdram_timing_pkg::XP_RST},
      {24'h0, sdram_timing_pkg::XSR_RST}};
    pat_v = '{32'h0000_0055, 32'h0000_000a, 32'h0000_0005, 32'h0000_002d, 32'h0000_02b6,
      32'h0000_0035, 32'h0000_0009, 32'h0000_0006, 32'h0000_0005, 32'h0000_00c3, 32'h0000_003c};
    prog_v = '{32'h0000_0003, 32'h0000_0004, 32'h0000_0006, 32'h0000_000a, 32'h0000_0045,
      32'h0000_0003, 32'h0000_0002, 32'h0000_0002, 32'h0000_0003, 32'h0000_0004, 32'h0000_0005};
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 11; i++) rd(ofs[i], rst_v[i]);
    for (int i = 0; i < 11; i++) wr(ofs[i], pat_v[i]);
    for (int i = 0; i < 11; i++) rd(ofs[i], pat_v[i]);
    rd(12'h048, 32'h0000_0000);
    st(sdram_timing_pkg::CTRL_READY);
    wr(ofs[0], 32'h0000_007f);
    rd(ofs[0], 32'h0000_0000);
    st(sdram_timing_pkg::CTRL_PAUSED);
    rd(ofs[0], 32'h0000_0000);
    st(sdram_timing_pkg::CTRL_LOW_POWER);
    rd(ofs[0], pat_v[0]);
    for (int i = 0; i < 11; i++) wr(ofs[i], prog_v[i]);
    st(sdram_timing_pkg::CTRL_READY);
    // Command bits: mode 10, activate 9, write 7, precharge 6, refresh 5,
    // power-down exit 4, self-refresh exit 3, write end 2, bank 1:0
    gap(11'h400, 16, 3);
    gap(11'h201, 8, 2);
    gap(11'h201, 4, 4);
    gap(11'h201, 12, 6);
    gap(11'h201, 11, 2);
    gap(11'h201, 2, 4);
    gap(11'h020, 16, 5);
    gap(11'h020, 1, 5);
    gap(11'h042, 13, 3);
    gap(11'h042, 0, 3);
    gap(11'h007, 6, 2);
    gap(11'h080, 15, 3);
    gap(11'h010, 16, 4);
    gap(11'h008, 16, 5);
    st(sdram_timing_pkg::CTRL_CONFIG);
    wr(ofs[8], 32'h0000_0000);
    gap(11'h080, 15, 0);
    final_report();
  end
endmodule
